/* hw/cfd_mapper.sv */
`timescale 1ns/1ps
module cfd_mapper
    import cfd_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         out_asm_valid_i,
    input  wire cfd_out_asm_t out_asm_i,
    output cfd_in_asm_t       in_asm_o,
    output logic              in_asm_valid_o,
    input  wire logic         msg_req_valid_i,
    input  wire cfd_msg_req_t msg_req_i,
    output logic              msg_rsp_valid_o,
    output logic [31:0]       msg_rsp_data_o,
    output logic              msg_rsp_err_o,
    input  wire cfd_drv_sts_t drv_sts_i,
    output cfd_drv_cmd_t      drv_cmd_o,
    output logic [15:0]       par_num_o,
    input  wire logic [63:0]  par_val_i,
    input  wire cfd_width_t   par_width_i,
    output logic              par_wr_o,
    output logic [31:0]       par_wr_data_o
);
    cfd_out_asm_t          cfg, next_cfg;
    logic                  pend, next_pend;
    logic [31:0]           status, next_status;
    cfd_drv_cmd_t          next_cmd;
    logic                  next_rsp_valid, next_rsp_err;
    logic [31:0]           next_rsp_data;
    logic [NSEL-1:0][31:0] sel_val;
    logic                  busy, scan_start, scan_done;
    cfd_item_t             item;
    logic [15:0]           inst_off;
    logic [1:0]            sub;
    logic                  path_ok, msg_bad, msg_wr_ok;
    logic [31:0]           rd_data;

    assign scan_start = pend && !busy;

    // ============================================================
    // explicit message decode
    // class, attribute, instance
    assign path_ok  = msg_req_i.cls == MSG_CLASS &&
                      msg_req_i.attr == MSG_ATTR;
    assign item     = path_ok ? item_of(msg_req_i.inst) : IT_NONE;
    assign inst_off = msg_req_i.inst - INST_RSEL;
    assign sub      = inst_off[1:0];

    // a write colliding with a cyclic frame is refused, not merged,
    // so the frame always lands whole
    always_comb begin
        msg_bad = (item == IT_NONE);
        if (msg_req_i.wr) begin
            if (item == IT_STS || item == IT_RVAL || out_asm_valid_i)
                msg_bad = 1'b1;
        end
    end

    assign msg_wr_ok = msg_req_valid_i && msg_req_i.wr && !msg_bad;

    always_comb begin
        case (item)
            IT_CTL:  rd_data = {RST16, cfg.ctl};
            IT_STS:  rd_data = status;
            IT_WSEL: rd_data = {RST16, cfg.wsel};
            IT_WVAL: rd_data = cfg.wval;
            IT_RSEL: rd_data = {RST16, cfg.rsel[sub]};
            IT_RVAL: rd_data = sel_val[sub];
            default: rd_data = RST32;
        endcase
    end

    // ============================================================
    // cyclic and explicit register file
    always_comb begin
        next_cfg  = cfg;
        next_pend = pend;
        if (scan_start)
            next_pend = 1'b0;
        if (out_asm_valid_i) begin
            next_cfg  = out_asm_i;
            next_pend = 1'b1;
        end else if (msg_wr_ok) begin
            case (item)
                IT_CTL:  next_cfg.ctl = msg_req_i.data[15:0];
                IT_WSEL: next_cfg.wsel = msg_req_i.data[15:0];
                IT_WVAL: next_cfg.wval = msg_req_i.data;
                IT_RSEL: next_cfg.rsel[sub] = msg_req_i.data[15:0];
                default: next_cfg = cfg;
            endcase
            // a new selector or payload reruns the scan
            if (item != IT_CTL)
                next_pend = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg  <= '0;
            pend <= 1'b0;
        end else begin
            cfg  <= next_cfg;
            pend <= next_pend;
        end
    end

    // ============================================================
    // control decode and status word
    always_comb begin
        next_cmd.net_control = cfg.ctl[CTL_NET];
        next_cmd.start_run   = cfg.ctl[CTL_RUN] & cfg.ctl[CTL_NET];
        next_cmd.ramp_freeze = cfg.ctl[CTL_FREEZE] & cfg.ctl[CTL_NET];
        next_cmd.fault_reset = cfg.ctl[CTL_RESET] & cfg.ctl[CTL_NET];
        next_cmd.ext_trip    = cfg.ctl[CTL_TRIP] & cfg.ctl[CTL_NET];
        next_status = RST32;
        next_status[STS_FAULT] = drv_sts_i.fault;
        next_status[STS_RUN]   = drv_sts_i.running;
        next_status[STS_DONE]  = drv_sts_i.ramp_complete;
        next_status[STS_ILIM]  = drv_sts_i.current_limited;
        next_status[STS_SAVE]  = drv_sts_i.energy_saving_active;
        next_status[STS_STOP]  = drv_sts_i.stopping;
        next_status[STS_NET]   = cfg.ctl[CTL_NET];
        if (drv_sts_i.fault)
            next_status[STS_CODE_HI:STS_CODE_LO] = drv_sts_i.trip_code;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status    <= RST32;
            drv_cmd_o <= '0;
        end else begin
            status    <= next_status;
            drv_cmd_o <= next_cmd;
        end
    end

    // ============================================================
    // explicit response
    always_comb begin
        next_rsp_valid = msg_req_valid_i;
        next_rsp_err   = msg_req_valid_i && msg_bad;
        next_rsp_data  = RST32;
        if (msg_req_valid_i && !msg_bad && !msg_req_i.wr)
            next_rsp_data = rd_data;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            msg_rsp_valid_o <= 1'b0;
            msg_rsp_err_o   <= 1'b0;
            msg_rsp_data_o  <= RST32;
        end else begin
            msg_rsp_valid_o <= next_rsp_valid;
            msg_rsp_err_o   <= next_rsp_err;
            msg_rsp_data_o  <= next_rsp_data;
        end
    end

    // ============================================================
    // parameter scan
    // payload write
    cfd_scan u_scan (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .start_i       (scan_start),
        .asm_i         (cfg),
        .par_val_i     (par_val_i),
        .par_width_i   (par_width_i),
        .par_num_o     (par_num_o),
        .par_wr_o      (par_wr_o),
        .par_wr_data_o (par_wr_data_o),
        .val_o         (sel_val),
        .busy_o        (busy),
        .done_o        (scan_done)
    );

    // ============================================================
    // input assembly
    // status then four values
    assign in_asm_o.status = status;
    assign in_asm_o.val    = sel_val;
    assign in_asm_valid_o  = scan_done;

    // ============================================================
    // checks
    a_ctl_decode: assert property (@(posedge clk_i) disable iff (rst_i)
        cfg.ctl[CTL_NET] |=>
        drv_cmd_o.start_run == $past(cfg.ctl[CTL_RUN]) &&
        drv_cmd_o.ramp_freeze == $past(cfg.ctl[CTL_FREEZE]) &&
        drv_cmd_o.fault_reset == $past(cfg.ctl[CTL_RESET]) &&
        drv_cmd_o.ext_trip == $past(cfg.ctl[CTL_TRIP]))
        else $error("control bit not passed with network control");

    a_net_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        !cfg.ctl[CTL_NET] |=> drv_cmd_o == '0)
        else $error("control bit acted without network control");

    a_status_map: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 status[STS_STOP:STS_FAULT] == $past({drv_sts_i.stopping,
            drv_sts_i.energy_saving_active, drv_sts_i.current_limited,
            drv_sts_i.ramp_complete, drv_sts_i.running, drv_sts_i.fault})
        && status[STS_RSV_HI:STS_RSV_LO] == '0)
        else $error("status bits do not follow drive state");

    a_trip_code: assert property (@(posedge clk_i) disable iff (rst_i)
        drv_sts_i.fault |=>
        in_asm_o.status[STS_CODE_HI:STS_CODE_LO] == $past(drv_sts_i.trip_code))
        else $error("trip code missing while tripped");

    a_code_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        !drv_sts_i.fault |=> in_asm_o.status[STS_CODE_HI:STS_CODE_LO] == '0)
        else $error("trip code shown without trip");

    a_net_mirror: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(cfg.ctl[CTL_NET]) |=>
        status[STS_NET] == drv_cmd_o.net_control &&
        status[STS_NET] == $past(cfg.ctl[CTL_NET]))
        else $error("network control status does not mirror control");

    a_scan_answer: assert property (@(posedge clk_i) disable iff (rst_i)
        scan_start |=> !in_asm_valid_o [*6] ##1 in_asm_valid_o)
        else $error("input assembly not refreshed seven cycles after scan");

    a_frame_scan: assert property (@(posedge clk_i) disable iff (rst_i)
        out_asm_valid_i |=> pend && cfg == $past(out_asm_i))
        else $error("output assembly not taken");

    a_msg_path: assert property (@(posedge clk_i) disable iff (rst_i)
        msg_req_valid_i && !path_ok |=> msg_rsp_valid_o && msg_rsp_err_o)
        else $error("bad explicit path not refused");

    a_msg_ro: assert property (@(posedge clk_i) disable iff (rst_i)
        msg_req_valid_i && msg_req_i.wr && item == IT_STS |=>
        msg_rsp_err_o && $stable(cfg))
        else $error("status accepted a write");

    a_msg_read: assert property (@(posedge clk_i) disable iff (rst_i)
        msg_req_valid_i && !msg_req_i.wr && item == IT_WVAL |=>
        !msg_rsp_err_o && msg_rsp_data_o == $past(cfg.wval))
        else $error("explicit read of payload wrong");
endmodule

/* common/cfd_pkg.sv */
// ============================================================
// cyclic fieldbus data mapper: shared definitions
package cfd_pkg;
    localparam int NSEL = 4;
    // control word bit positions
    localparam int CTL_RUN    = 0;
    localparam int CTL_FREEZE = 1;
    localparam int CTL_RESET  = 2;
    localparam int CTL_TRIP   = 3;
    localparam int CTL_NET    = 4;
    // status word bit positions
    localparam int STS_FAULT  = 0;
    localparam int STS_RUN    = 1;
    localparam int STS_DONE   = 2;
    localparam int STS_ILIM   = 3;
    localparam int STS_SAVE   = 4;
    localparam int STS_STOP   = 5;
    localparam int STS_NET    = 6;
    localparam int STS_RSV_HI = 15;
    localparam int STS_RSV_LO = 7;
    localparam int STS_CODE_LO = 16;
    localparam int STS_CODE_HI = 31;
    // explicit message addressing
    localparam logic [7:0]  MSG_CLASS = 8'hA2;
    localparam logic [7:0]  MSG_ATTR  = 8'h05;
    localparam logic [15:0] INST_CTL  = 16'h0002;
    localparam logic [15:0] INST_STS  = 16'h0003;
    localparam logic [15:0] INST_WSEL = 16'h0100;
    localparam logic [15:0] INST_WVAL = 16'h0101;
    localparam logic [15:0] INST_RSEL = 16'h0102;
    localparam logic [15:0] INST_RVAL = 16'h0106;
    localparam logic [15:0] INST_LAST = 16'h0109;
    // reset values and the null selector
    localparam logic [15:0] SEL_NONE = 16'h0000;
    localparam logic [15:0] RST16    = 16'h0000;
    localparam logic [31:0] RST32    = 32'h0000_0000;

    typedef enum logic [1:0] {
        W16 = 2'b00, W32 = 2'b01, W64 = 2'b10, W8 = 2'b11
    } cfd_width_t;

    typedef enum logic [2:0] {
        IT_CTL  = 3'b000, IT_STS  = 3'b001, IT_WSEL = 3'b010,
        IT_WVAL = 3'b011, IT_RSEL = 3'b100, IT_RVAL = 3'b101,
        IT_NONE = 3'b110
    } cfd_item_t;

    // output assembly; write payload is one 32-bit item
    typedef struct packed {
        logic [15:0]           ctl;
        logic [15:0]           wsel;
        logic [31:0]           wval;
        logic [NSEL-1:0][15:0] rsel;
    } cfd_out_asm_t;

    typedef struct packed {
        logic [31:0]           status;
        logic [NSEL-1:0][31:0] val;
    } cfd_in_asm_t;

    typedef struct packed {
        logic        wr;
        logic [7:0]  cls;
        logic [15:0] inst;
        logic [7:0]  attr;
        logic [31:0] data;
    } cfd_msg_req_t;

    typedef struct packed {
        logic        fault;
        logic        running;
        logic        ramp_complete;
        logic        current_limited;
        logic        energy_saving_active;
        logic        stopping;
        logic [15:0] trip_code;
    } cfd_drv_sts_t;

    typedef struct packed {
        logic start_run;
        logic ramp_freeze;
        logic fault_reset;
        logic ext_trip;
        logic net_control;
    } cfd_drv_cmd_t;

    // keep the low bits that fit the parameter, at most the low 32, drop the rest
    function automatic logic [31:0] fit_value(input logic [63:0] v,
                                              input cfd_width_t  w);
        case (w)
            W8:      fit_value = {24'h00_0000, v[7:0]};
            W16:     fit_value = {16'h0000, v[15:0]};
            default: fit_value = v[31:0];
        endcase
    endfunction

    function automatic cfd_item_t item_of(input logic [15:0] inst);
        if (inst == INST_CTL)
            item_of = IT_CTL;
        else if (inst == INST_STS)
            item_of = IT_STS;
        else if (inst == INST_WSEL)
            item_of = IT_WSEL;
        else if (inst == INST_WVAL)
            item_of = IT_WVAL;
        else if (inst >= INST_RSEL && inst < INST_RVAL)
            item_of = IT_RSEL;
        else if (inst >= INST_RVAL && inst <= INST_LAST)
            item_of = IT_RVAL;
        else
            item_of = IT_NONE;
    endfunction
endpackage

/* hw/cfd_scan.sv */
`timescale 1ns/1ps
module cfd_scan
    import cfd_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  start_i,
    input  wire cfd_out_asm_t          asm_i,
    input  wire logic [63:0]           par_val_i,
    input  wire cfd_width_t            par_width_i,
    output logic      [15:0]           par_num_o,
    output logic                       par_wr_o,
    output logic      [31:0]           par_wr_data_o,
    output logic      [NSEL-1:0][31:0] val_o,
    output logic                       busy_o,
    output logic                       done_o
);
    typedef enum logic [1:0] {
        S_IDLE = 2'b00, S_WQRY = 2'b01, S_WRITE = 2'b10, S_READ = 2'b11
    } cfd_scan_t;

    cfd_scan_t             state, next_state;
    cfd_out_asm_t          snap, next_snap;
    logic [1:0]            idx, next_idx;
    logic [15:0]           next_num;
    logic                  next_wr, next_done;
    logic [31:0]           next_wdata;
    logic [NSEL-1:0][31:0] next_val;

    // ============================================================
    // scan sequencer
    always_comb begin
        next_state = state;
        next_snap  = snap;
        next_idx   = idx;
        next_num   = par_num_o;
        next_wr    = 1'b0;
        next_done  = 1'b0;
        next_wdata = par_wr_data_o;
        next_val   = val_o;
        case (state)
            S_IDLE: begin
                if (start_i) begin
                    next_snap  = asm_i;
                    next_num   = asm_i.wsel;
                    next_state = S_WQRY;
                end
            end
            S_WQRY: begin
                next_wdata = fit_value({RST32, snap.wval}, par_width_i);
                next_wr    = (snap.wsel != SEL_NONE);
                next_state = S_WRITE;
            end
            S_WRITE: begin
                next_idx   = 2'b00;
                next_num   = snap.rsel[0];
                next_state = S_READ;
            end
            S_READ: begin
                if (snap.rsel[idx] == SEL_NONE)
                    next_val[idx] = RST32;
                else
                    next_val[idx] = fit_value(par_val_i, par_width_i);
                if (idx == 2'(NSEL - 1)) begin
                    next_done  = 1'b1;
                    next_state = S_IDLE;
                end else begin
                    next_idx = 2'(idx + 2'b01);
                    next_num = snap.rsel[2'(idx + 2'b01)];
                end
            end
            default: next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state         <= S_IDLE;
            snap          <= '0;
            idx           <= 2'b00;
            par_num_o     <= RST16;
            par_wr_o      <= 1'b0;
            par_wr_data_o <= RST32;
            val_o         <= '0;
            done_o        <= 1'b0;
        end else begin
            state         <= next_state;
            snap          <= next_snap;
            idx           <= next_idx;
            par_num_o     <= next_num;
            par_wr_o      <= next_wr;
            par_wr_data_o <= next_wdata;
            val_o         <= next_val;
            done_o        <= next_done;
        end
    end

    assign busy_o = (state != S_IDLE);

    // ============================================================
    // checks
    a_write_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        par_wr_o |-> par_num_o == snap.wsel && snap.wsel != SEL_NONE)
        else $error("parameter write with null selector");
    a_write_trunc: assert property (@(posedge clk_i) disable iff (rst_i)
        state == S_WQRY && par_width_i == W16 |=>
        par_wr_data_o == {16'h0000, snap.wval[15:0]})
        else $error("narrow write kept upper bytes");
    a_zero_select: assert property (@(posedge clk_i) disable iff (rst_i)
        state == S_READ && snap.rsel[idx] == SEL_NONE |=>
        val_o[$past(idx)] == RST32)
        else $error("null read selector gave nonzero value");
    a_read_order: assert property (@(posedge clk_i) disable iff (rst_i)
        state == S_READ |-> par_num_o == snap.rsel[idx])
        else $error("read selector out of order");
    a_read_fit: assert property (@(posedge clk_i) disable iff (rst_i)
        state == S_READ && snap.rsel[idx] != SEL_NONE |=>
        val_o[$past(idx)] == $past(par_val_i[31:0]) ||
        $past(par_width_i) == W16 || $past(par_width_i) == W8)
        else $error("wide value not cut to low word");
endmodule

/* sim/cfd_param_model.sv */
`timescale 1ns/1ps
// ==========================================
// parameter store behind the parameter port
module cfd_param_model
    import cfd_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic [15:0] par_num_i,
    input  wire logic        par_wr_i,
    input  wire logic [31:0] par_wr_data_i,
    output logic      [63:0] par_val_o,
    output cfd_width_t       par_width_o,
    output int               wr_cnt_o,
    output logic      [15:0] wr_num_o,
    output logic      [31:0] wr_data_o
);
    // low two number bits pick the width, so every width is reachable
    assign par_width_o = cfd_width_t'(par_num_i[1:0]);
    // upper half nonzero so that a missing truncation shows up
    assign par_val_o = {16'hC3C3, par_num_i, 16'h5A5A, par_num_i};
    initial wr_cnt_o = 0;
    always @(posedge clk_i) begin
        if (par_wr_i) begin
            wr_cnt_o  <= wr_cnt_o + 1;
            wr_num_o  <= par_num_i;
            wr_data_o <= par_wr_data_i;
        end
    end
endmodule

/* sim/cfd_mapper_tb.sv */
`timescale 1ns/1ps
module cfd_mapper_tb;
    import cfd_pkg::*;
    logic         clk_i = 1'b0;
    logic         rst_i = 1'b1;
    logic         oav   = 1'b0;
    cfd_out_asm_t oa    = '0;
    logic         mv    = 1'b0;
    cfd_msg_req_t mr    = '0;
    cfd_drv_sts_t ds    = '0;
    cfd_in_asm_t  ia;
    cfd_drv_cmd_t dc;
    cfd_width_t   pw;
    logic         iav, rv, re, pwr;
    logic  [31:0] rd, pwd, wd;
    logic  [15:0] pn, wn;
    logic  [63:0] pv;
    logic  [31:0] ex [12];
    int           wc, k;
    int           n_errors = 0;
    int           n_checks = 0;

    always #25 clk_i = ~clk_i;

    cfd_mapper uut (
        .clk_i(clk_i), .rst_i(rst_i),
        .out_asm_valid_i(oav), .out_asm_i(oa),
        .in_asm_o(ia), .in_asm_valid_o(iav),
        .msg_req_valid_i(mv), .msg_req_i(mr),
        .msg_rsp_valid_o(rv), .msg_rsp_data_o(rd), .msg_rsp_err_o(re),
        .drv_sts_i(ds), .drv_cmd_o(dc), .par_num_o(pn),
        .par_val_i(pv), .par_width_i(pw),
        .par_wr_o(pwr), .par_wr_data_o(pwd)
    );

    cfd_param_model mdl (
        .clk_i(clk_i), .par_num_i(pn), .par_wr_i(pwr),
        .par_wr_data_i(pwd), .par_val_o(pv), .par_width_o(pw),
        .wr_cnt_o(wc), .wr_num_o(wn), .wr_data_o(wd)
    );

    // ==========================================
    // expectations and checks
    function automatic logic [31:0] fitx(input logic [15:0] n,
                                         input logic [31:0] v);
        case (n[1:0])
            2'b00:   fitx = {16'h0000, v[15:0]};
            2'b11:   fitx = {24'h00_0000, v[7:0]};
            default: fitx = v;
        endcase
    endfunction

    function automatic logic [31:0] expv(input logic [15:0] n);
        expv = (n == 16'h0000) ? 32'h0000_0000 : fitx(n, {16'h5A5A, n});
    endfunction

    function automatic logic [31:0] cmdx(input logic [15:0] c);
        cmdx = c[4] ? {27'h0, c[0], c[1], c[2], c[3], 1'b1} : 32'h0;
    endfunction

    function automatic logic [31:0] stsx(input logic [15:0] c);
        stsx = {ds.fault ? ds.trip_code : 16'h0000, 9'h000, c[4],
                ds.stopping, ds.energy_saving_active, ds.current_limited,
                ds.ramp_complete, ds.running, ds.fault};
    endfunction

    task automatic finish_test();
        if (n_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_scan();
        int i;
        for (i = 0; i < 20 && iav !== 1'b1; i++)
            @(negedge clk_i);
        if (i == 20) begin
            n_errors++;
            finish_test();
        end
    endtask

    // the whole output assembly rides with every frame: control, write selector, payload, read selectors
    task automatic frame(input logic [15:0] c, input logic [15:0] w,
                         input logic [31:0] v, input logic [63:0] r);
        int c0;
        int i;
        c0 = wc;
        oa = {c, w, v, r};
        oav = 1'b1;
        @(negedge clk_i);
        oav = 1'b0;
        wait_scan();
        for (i = 0; i < NSEL; i++)
            chk(ia.val[i], expv(r[i*16 +: 16]));
        chk(ia.status, stsx(c));
        chk({27'h0, dc}, cmdx(c));
        chk(wc - c0, (w != 16'h0000) ? 1 : 0);
        if (w != 16'h0000) begin
            chk(wd, fitx(w, v));
            chk({16'h0000, wn}, {16'h0000, w});
        end
    endtask

    // explicit request; response is due one cycle after the request.
    // the valid stays up so back to back calls never toggle it in one
    // time step; the caller lowers it after the last request
    task automatic msg(input logic w, input logic [7:0] cl,
                       input logic [7:0] at, input logic [15:0] in,
                       input logic [31:0] d, input logic ee,
                       input logic [31:0] ed);
        mr = {w, cl, in, at, d};
        mv = 1'b1;
        @(negedge clk_i);
        chk({30'h0, rv, re}, {30'h0, 1'b1, ee});
        chk(rd, ed);
    endtask

    // ==========================================
    // main sequence
    initial begin
        repeat (4) @(negedge clk_i);
        rst_i = 1'b0;
        chk(ia.status, 32'h0000_0000);
        chk({27'h0, dc}, 32'h0000_0000);
        ds = {6'b010101, 16'hBEEF};
        frame(16'hFFEF, 16'h0011, 32'hDEAD_BEEF, 64'h0000_0002_0007_0004);
        ds = {6'b101010, 16'hBEEF};
        frame(16'hFFFF, 16'h0020, 32'h1234_5678, 64'h0105_0103_0102_0101);
        frame(16'h0015, 16'h0000, 32'h89AB_CDEF, 64'h0000_0108_0106_0003);
        ex = '{32'h0000_0015, stsx(16'h0015), 32'h0, 32'h89AB_CDEF,
               32'h0000_0003, 32'h0000_0106, 32'h0000_0108, 32'h0,
               expv(16'h0003), expv(16'h0106), expv(16'h0108), 32'h0};
        for (k = 0; k < 12; k++)
            msg(1'b0, MSG_CLASS, MSG_ATTR, (k == 0) ? INST_CTL :
                (k == 1) ? INST_STS : INST_WSEL + 16'(k - 2),
                32'h0, 1'b0, ex[k]);
        msg(1'b1, MSG_CLASS, MSG_ATTR, INST_STS, 32'h1, 1'b1, 32'h0);
        msg(1'b1, MSG_CLASS, MSG_ATTR, INST_RVAL, 32'h1, 1'b1, 32'h0);
        msg(1'b0, 8'hA3, MSG_ATTR, INST_CTL, 32'h0, 1'b1, 32'h0);
        msg(1'b0, MSG_CLASS, 8'h06, INST_CTL, 32'h0, 1'b1, 32'h0);
        msg(1'b0, MSG_CLASS, MSG_ATTR, 16'h010A, 32'h0, 1'b1, 32'h0);
        msg(1'b1, MSG_CLASS, MSG_ATTR, INST_CTL, 32'hFFFF_001B, 1'b0,
            32'h0);
        mv = 1'b0;
        @(negedge clk_i);
        chk({27'h0, dc}, cmdx(16'h001B));
        msg(1'b0, MSG_CLASS, MSG_ATTR, INST_CTL, 32'h0, 1'b0,
            32'h0000_001B);
        msg(1'b1, MSG_CLASS, MSG_ATTR, 16'h0105, 32'h0000_0007, 1'b0,
            32'h0);
        mv = 1'b0;
        wait_scan();
        chk(ia.val[3], expv(16'h0007));
        finish_test();
    end
endmodule
